// file: verilog/ir_panel_pkg.sv
package ir_panel_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_PERIOD_NS = 10;
	// Output delay budget after an SCL fall.
	localparam int DATA_DELAY_NS = 3000;
	localparam int DATA_DELAY_CYC = DATA_DELAY_NS / CLK_PERIOD_NS;
	// The bit is driven a few cycles after the fall, well inside the budget.
	localparam int DRIVE_LAG_CYC = 4;
	// Infrared symbol timing.
	localparam int IR_T_US = 580;
	localparam int IR_TOL_US = 300;
	localparam int IR_T_CYC = IR_T_US * (CLK_HZ / 1_000_000);
	localparam int IR_TOL_CYC = IR_TOL_US * (CLK_HZ / 1_000_000);
	localparam int IR_BITS = 8;
	localparam int BUF_DEPTH = 16;
	localparam int READ_MAX = 15;
	localparam int KEYS = 8;
	localparam logic [6:0] OWN_ADDR_DEF = 7'h62;
	localparam int TIMEOUT_US = 25000;
	localparam int TIMEOUT_CYC = TIMEOUT_US * (CLK_HZ / 1_000_000);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_WRITE = 3'b011,
		ST_WACK = 3'b100,
		ST_READ = 3'b101,
		ST_RACK = 3'b110,
		ST_WAIT = 3'b111
	} i2c_state_e;
	typedef enum logic [1:0] {
		IR_IDLE = 2'b00,
		IR_BURST = 2'b01,
		IR_GAP = 2'b10
	} ir_state_e;
endpackage

// file: verilog/ir_pulse_decoder.sv
`timescale 1ns/1ps
module ir_pulse_decoder
	import ir_panel_pkg::*;
#(
	parameter int T_CYC = IR_T_CYC,
	parameter int TOL_CYC = IR_TOL_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ir_burst,
	output logic [7:0] o_byte,
	output logic o_byte_valid
);
	// ****************************************
	// Burst and gap timing
	// ****************************************
	ir_state_e state_q;
	logic [31:0] cnt_q;
	logic [3:0] nbits_q;
	logic [7:0] shift_q;
	logic burst_q;

	// Carrier is seen as a level from the demodulating receiver; an over-long gap resets the frame.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= IR_IDLE;
			cnt_q <= 32'h0;
			nbits_q <= 4'h0;
			shift_q <= 8'h00;
			burst_q <= 1'b0;
			o_byte <= 8'h00;
			o_byte_valid <= 1'b0;
		end else begin
			burst_q <= i_ir_burst;
			o_byte_valid <= 1'b0;
			cnt_q <= cnt_q + 32'h1;
			case (state_q)
				IR_IDLE: begin
					if (i_ir_burst && !burst_q) begin
						state_q <= IR_BURST;
						cnt_q <= 32'h0;
					end
				end
				IR_BURST: begin
					if (!i_ir_burst) begin
						if (cnt_q + 32'(TOL_CYC) >= 32'(T_CYC) && cnt_q <= 32'(T_CYC + TOL_CYC)) begin
							state_q <= IR_GAP;
						end else begin
							state_q <= IR_IDLE;
							nbits_q <= 4'h0;
						end
						cnt_q <= 32'h0;
					end
				end
				IR_GAP: begin
					if (i_ir_burst) begin
						state_q <= IR_BURST;
						cnt_q <= 32'h0;
						if (cnt_q + 32'(TOL_CYC) >= 32'(T_CYC) && cnt_q <= 32'(T_CYC + TOL_CYC)) begin
							shift_q <= {shift_q[6:0], 1'b0};
							nbits_q <= nbits_q + 4'h1;
						end else if (cnt_q + 32'(TOL_CYC) >= 32'(3 * T_CYC) && cnt_q <= 32'(3 * T_CYC + TOL_CYC)) begin
							shift_q <= {shift_q[6:0], 1'b1};
							nbits_q <= nbits_q + 4'h1;
						end else begin
							nbits_q <= 4'h0;
						end
					end else if (cnt_q > 32'(3 * T_CYC + TOL_CYC)) begin
						state_q <= IR_IDLE;
						nbits_q <= 4'h0;
					end
					if (nbits_q == 4'(IR_BITS)) begin
						o_byte <= shift_q;
						o_byte_valid <= 1'b1;
						nbits_q <= 4'h0;
					end
				end
				default: state_q <= IR_IDLE;
			endcase
		end
	end
endmodule

// file: verilog/ir_front_panel_i2c_slave.sv
`timescale 1ns/1ps
// How it works
// - ACK own address after eighth bit
// - Shift read bytes out on SCL falls
// - Data bit valid within 3 us
// - Arm stop detect on first read rise
// - Release SDA, sample master acknowledge
// - Re-arm stop detect on acknowledge clock rise
// - Stop halts transaction time-out timer
// - Data-ready high until data fetched
// - Key press stores code, raises ready
// - Burst T, gap T is zero
// - Burst T, gap 3T is one
// - Accept 0.3 ms timing deviation
// - Up to 15 bytes, stored order
// - Written bytes stored in buffer
module ir_front_panel_i2c_slave
	import ir_panel_pkg::*;
#(
	parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEF,
	parameter int DEPTH = BUF_DEPTH,
	parameter int T_CYC = IR_T_CYC,
	parameter int TOL_CYC = IR_TOL_CYC,
	parameter int TMO_CYC = TIMEOUT_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_ir_burst,
	input wire logic [KEYS-1:0] i_key,
	output logic o_data_ready_out,
	output logic o_timeout
);
	localparam int AW = $clog2(DEPTH);
	// ****************************************
	// Bus edges and conditions
	// ****************************************
	logic scl_q, sda_q, stop_arm_q;
	logic scl_rise, scl_fall, start_seen, stop_raw, stop_seen;
	i2c_state_e state_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end
	assign scl_rise = i_scl && !scl_q;
	assign scl_fall = !i_scl && scl_q;
	assign start_seen = i_scl && scl_q && sda_q && !i_sda;
	assign stop_raw = i_scl && scl_q && !sda_q && i_sda;
	// Stop detection only listens while armed, so our own data edges never fake a stop.
	assign stop_seen = stop_raw && stop_arm_q;
	// ****************************************
	// Buffer
	// ****************************************
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q, cnt_d;
	logic [7:0] ir_byte, key_code, rx_q, push_data;
	logic ir_valid, key_hit, i2c_wr, pop, push;
	logic [KEYS-1:0] key_q;
	ir_pulse_decoder #(
		.T_CYC(T_CYC),
		.TOL_CYC(TOL_CYC)
	) u_ir (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_ir_burst(i_ir_burst),
		.o_byte(ir_byte),
		.o_byte_valid(ir_valid)
	);
	always_comb begin
		key_hit = 1'b0;
		key_code = 8'h00;
		for (int k = 0; k < KEYS; k++) begin
			if (i_key[k] && !key_q[k] && !key_hit) begin
				key_hit = 1'b1;
				key_code = 8'(k) | 8'h80;
			end
		end
	end
	// Only one writer per cycle: bus data first, then infrared, then keys; a loser is dropped.
	assign push = (i2c_wr || ir_valid || key_hit) && (cnt_q < (AW+1)'(DEPTH));
	assign push_data = i2c_wr ? rx_q : (ir_valid ? ir_byte : key_code);
	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem[wr_q] <= push_data;
		end
	end
	always_comb begin
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop && cnt_q != '0);
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			key_q <= '0;
			o_data_ready_out <= 1'b0;
		end else begin
			key_q <= i_key;
			cnt_q <= cnt_d;
			o_data_ready_out <= (cnt_d != '0);
			if (push) begin
				wr_q <= AW'((wr_q + AW'(1)) % DEPTH);
			end
			if (pop && cnt_q != '0) begin
				rd_q <= AW'((rd_q + AW'(1)) % DEPTH);
			end
		end
	end
	// ****************************************
	// Protocol engine
	// ****************************************
	logic [3:0] bit_q, nread_q;
	logic [7:0] tx_q, lag_q;
	logic rd_dir_q, drive_q, drive_val_q, tmo_run_q;
	logic [31:0] tmo_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= ST_IDLE;
			bit_q <= 4'h0;
			rx_q <= 8'h00;
			tx_q <= 8'h00;
			rd_dir_q <= 1'b0;
			nread_q <= 4'h0;
			drive_q <= 1'b0;
			drive_val_q <= 1'b1;
			stop_arm_q <= 1'b1;
			i2c_wr <= 1'b0;
			pop <= 1'b0;
		end else begin
			i2c_wr <= 1'b0;
			pop <= 1'b0;
			if (start_seen) begin
				state_q <= ST_ADDR;
				bit_q <= 4'h0;
				drive_q <= 1'b0;
				stop_arm_q <= 1'b1;
				nread_q <= 4'h0;
			end else if (stop_seen) begin
				state_q <= ST_IDLE;
				drive_q <= 1'b0;
				stop_arm_q <= 1'b1;
			end else begin
				case (state_q)
					ST_IDLE: drive_q <= 1'b0;
					ST_ADDR, ST_WRITE: begin
						if (scl_rise) begin
							rx_q <= {rx_q[6:0], i_sda};
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h0) begin
								stop_arm_q <= 1'b1;
							end
						end
						if (scl_fall && bit_q != 4'h0) begin
							stop_arm_q <= 1'b0;
						end
						if (scl_fall && bit_q == 4'h8) begin
							bit_q <= 4'h0;
							if (state_q == ST_ADDR && rx_q[7:1] != OWN_ADDR) begin
								state_q <= ST_WAIT;
							end else begin
								drive_q <= 1'b1;
								drive_val_q <= 1'b0;
								if (state_q == ST_ADDR) begin
									rd_dir_q <= rx_q[0];
									state_q <= ST_AACK;
								end else begin
									i2c_wr <= 1'b1;
									state_q <= ST_WACK;
								end
							end
						end
					end
					ST_AACK, ST_WACK: begin
						if (scl_rise) begin
							stop_arm_q <= 1'b0;
						end
						if (scl_fall) begin
							if (state_q == ST_AACK && rd_dir_q) begin
								tx_q <= {mem[rd_q][6:0], 1'b0};
								drive_val_q <= mem[rd_q][7];
								drive_q <= 1'b1;
								pop <= 1'b1;
								nread_q <= 4'h1;
								bit_q <= 4'h1;
								state_q <= ST_READ;
							end else begin
								drive_q <= 1'b0;
								state_q <= ST_WRITE;
							end
						end
					end
					ST_READ: begin
						if (scl_rise && bit_q == 4'h1) begin
							stop_arm_q <= 1'b1;
						end
						if (scl_fall) begin
							stop_arm_q <= 1'b0;
							if (bit_q == 4'h8) begin
								drive_q <= 1'b0;
								state_q <= ST_RACK;
							end else begin
								drive_val_q <= tx_q[7];
								tx_q <= {tx_q[6:0], 1'b0};
								bit_q <= bit_q + 4'h1;
							end
						end
					end
					ST_RACK: begin
						if (scl_rise) begin
							stop_arm_q <= 1'b1;
							if (i_sda || nread_q == 4'(READ_MAX)) begin
								state_q <= ST_WAIT;
							end
						end
						if (scl_fall) begin
							tx_q <= {mem[rd_q][6:0], 1'b0};
							drive_val_q <= mem[rd_q][7];
							drive_q <= 1'b1;
							pop <= 1'b1;
							nread_q <= nread_q + 4'h1;
							bit_q <= 4'h1;
							state_q <= ST_READ;
						end
					end
					ST_WAIT: begin
						drive_q <= 1'b0;
						stop_arm_q <= 1'b1;
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			lag_q <= 8'h00;
			o_sda <= 1'b1;
			o_sda_oe <= 1'b0;
		end else begin
			lag_q <= scl_fall ? 8'h00 : (lag_q == 8'hff ? lag_q : lag_q + 8'h01);
			if (!drive_q) begin
				o_sda_oe <= 1'b0;
				o_sda <= 1'b1;
			end else if (lag_q == 8'(DRIVE_LAG_CYC) && DRIVE_LAG_CYC < DATA_DELAY_CYC) begin
				o_sda_oe <= !drive_val_q;
				o_sda <= 1'b0;
			end
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tmo_q <= 32'h0;
			tmo_run_q <= 1'b0;
			o_timeout <= 1'b0;
		end else begin
			o_timeout <= 1'b0;
			if (start_seen) begin
				tmo_run_q <= 1'b1;
				tmo_q <= 32'h0;
			end else if (stop_seen) begin
				tmo_run_q <= 1'b0;
			end else if (tmo_run_q) begin
				tmo_q <= tmo_q + 32'h1;
				if (tmo_q == 32'(TMO_CYC)) begin
					o_timeout <= 1'b1;
					tmo_run_q <= 1'b0;
				end
			end
		end
	end
endmodule

// file: tb/ir_front_panel_i2c_slave_asserts.sv
`timescale 1ns/1ps
module ir_panel_slave_checker
	import ir_panel_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic i_ir_burst,
	input wire logic [KEYS-1:0] i_key,
	input wire logic o_data_ready_out,
	input wire logic o_timeout
);
	// ****
	// Bus state seen from the pins
	// ****
	logic scl_q, sda_q, idle_q;
	logic [9:0] low_q;
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end
	// An SDA edge while SCL stays high is a start or stop, so idle runs from stop to start.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) idle_q <= 1'b1;
		else if (scl_q && i_scl && sda_q != i_sda) idle_q <= i_sda;
	end
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) low_q <= '0;
		else if (scl_q && !i_scl) low_q <= '0;
		else if (low_q != 10'h3ff) low_q <= low_q + 10'h1;
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	property p_open_drain; o_sda_oe |-> o_sda == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("sda driven high");
	property p_drive_lag; $changed(o_sda_oe) |-> !i_scl && low_q < 10'h12c; endproperty
	a_drive_lag: assert property (p_drive_lag) else $error("sda change late");
	property p_hold_at_rise; $rose(i_scl) |-> $stable(o_sda_oe) [*4]; endproperty
	a_hold_at_rise: assert property (p_hold_at_rise) else $error("sda moved at rise");
	property p_key_ready; |(i_key & ~$past(i_key)) |-> ##[1:8] o_data_ready_out; endproperty
	a_key_ready: assert property (p_key_ready) else $error("no ready after key");
	property p_ready_hold; o_data_ready_out && idle_q |=> o_data_ready_out; endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("ready lost while idle");
	property p_idle_quiet; idle_q |-> !o_sda_oe; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven while idle");
	property p_idle_no_timeout; idle_q |-> !o_timeout; endproperty
	a_idle_no_timeout: assert property (p_idle_no_timeout) else $error("timeout after stop");
	property p_timeout_pulse; o_timeout |=> !o_timeout; endproperty
	a_timeout_pulse: assert property (p_timeout_pulse) else $error("timeout not a pulse");
	c_key: cover property (|(i_key & ~$past(i_key)));
	c_timeout: cover property (o_timeout);
	c_ack_drive: cover property ($rose(o_sda_oe));
endmodule

// file: tb/ir_panel_i2c_master.sv
`timescale 1ns/1ps
module ir_panel_i2c_master #(
	parameter int HALF = 400
) (
	input wire logic i_mclk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	// ****
	// Bus master tasks
	// ****
	logic [8:0] seen;
	event got;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic hp(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic start();
		o_sda <= 1'b0;
		hp(HALF);
		o_scl <= 1'b0;
	endtask
	// halves of 4 us, sampled 3 us after fall
	task automatic bit_io(input logic b, output logic r);
		o_sda <= b;
		hp(300);
		r = i_sda;
		hp(HALF - 300);
		o_scl <= 1'b1;
		hp(HALF);
		o_scl <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] tx, input logic ak);
		logic r;
		for (int i = 7; i >= -1; i--) begin
			bit_io(i >= 0 ? tx[i & 7] : ak, r);
			seen[i + 1] = r;
		end
		->got;
	endtask
	task automatic stop();
		o_sda <= 1'b0;
		hp(HALF);
		o_scl <= 1'b1;
		hp(HALF);
		o_sda <= 1'b1;
		hp(HALF);
	endtask
endmodule

// file: tb/ir_front_panel_i2c_slave_tb_top.sv
`timescale 1ns/1ps
module ir_front_panel_i2c_slave_tb_top;
	import ir_panel_pkg::*;
	localparam int T = 290;
	logic i_mclk, i_rstn, scl, m_sda, i_sda, o_sda, o_sda_oe, i_ir_burst, o_data_ready_out, o_timeout;
	logic [KEYS-1:0] i_key;
	logic [8:0] exp_q[$];
	logic [7:0] wd, irb;
	int mismatches, compares, k, n;
	// ****
	// Wiring and clock
	// ****
	assign i_sda = m_sda & ~(o_sda_oe & ~o_sda);
	ir_front_panel_i2c_slave #(.T_CYC(T), .TOL_CYC(150), .TMO_CYC(20000)) uut (.i_mclk, .i_rstn, .i_scl(scl),
		.i_sda, .o_sda, .o_sda_oe, .i_ir_burst, .i_key, .o_data_ready_out, .o_timeout);
	ir_panel_i2c_master #(.HALF(400)) m (.i_mclk, .i_sda, .o_scl(scl), .o_sda(m_sda));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic ir_send(input logic [7:0] b);
		for (int i = 7; i >= -1; i--) begin
			i_ir_burst <= 1'b1;
			repeat (T - 60 + $urandom % 120) @(posedge i_mclk);
			i_ir_burst <= 1'b0;
			if (i >= 0) repeat ((b[i & 7] ? 3 * T : T) + 60) @(posedge i_mclk);
		end
		repeat (5 * T) @(posedge i_mclk);
	endtask
	initial forever begin
		@(m.got);
		chk(m.seen, exp_q.pop_front());
	end
	initial begin
		repeat (99000) @(posedge i_mclk);
		mismatches++;
		finish_test();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		i_rstn = 1'b0;
		i_key = '0;
		i_ir_burst = 1'b0;
		mismatches = 0;
		compares = 0;
		k = $urandom(32'h96a8);
		k = $urandom % KEYS;
		wd = $urandom;
		irb = $urandom;
		repeat (8) @(posedge i_mclk);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_mclk);
		chk({o_sda_oe, 7'h0, o_data_ready_out}, 9'h000);
		i_key <= 8'h01 << k;
		repeat (20) @(posedge i_mclk);
		i_key <= '0;
		@(posedge i_mclk);
		chk({8'h00, o_data_ready_out}, 9'h001);
		exp_q.push_back({OWN_ADDR_DEF, 2'b00});
		exp_q.push_back({wd, 1'b0});
		m.start();
		m.xfer({OWN_ADDR_DEF, 1'b0}, 1'b1);
		m.xfer(wd, 1'b1);
		m.stop();
		ir_send(irb);
		exp_q.push_back({OWN_ADDR_DEF, 2'b10});
		exp_q.push_back({8'h80 | 8'(k), 1'b0});
		exp_q.push_back({wd, 1'b0});
		exp_q.push_back({irb, 1'b1});
		m.start();
		m.xfer({OWN_ADDR_DEF, 1'b1}, 1'b1);
		m.xfer(8'hff, 1'b0);
		m.xfer(8'hff, 1'b0);
		m.xfer(8'hff, 1'b1);
		m.stop();
		chk({8'h00, o_data_ready_out}, 9'h000);
		exp_q.push_back({OWN_ADDR_DEF ^ 7'h01, 2'b01});
		m.start();
		m.xfer({OWN_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1);
		for (n = 0; n < 20000 && o_timeout !== 1'b1; n++) @(posedge i_mclk);
		chk({8'h00, o_timeout}, 9'h001);
		m.stop();
		finish_test();
	end
endmodule
bind ir_front_panel_i2c_slave ir_panel_slave_checker chk_i (.i_mclk, .i_rstn, .i_scl, .i_sda, .o_sda, .o_sda_oe,
	.i_ir_burst, .i_key, .o_data_ready_out, .o_timeout);
